// [hw/fpec_top.v]
/*
 flash program/erase control: control and key registers on AXI4-Lite,
 unlock check, operation decode, self-timed run, status interrupt.
 assumes rst_n_i is power-on reset, sys_rst_i any other reset,
 table writes come from the core with the address already advanced.
*/
`timescale 1ns/100ps
`include "fpec_defs.vh"
module fpec_top #(
	parameter TW = 16,
	parameter LAW = 6
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire ce_i,
	input wire sys_rst_i,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire table_write_low_i,
	input wire table_write_high_i,
	input wire [LAW-1:0] table_addr_i,
	input wire [15:0] table_low_i,
	input wire [7:0] table_high_i,
	output reg flash_start_o,
	output reg [2:0] flash_cmd_o,
	output reg flash_busy_o,
	input wire flash_fault_i,
	input wire [LAW-1:0] flash_latch_addr_i,
	output wire [23:0] flash_latch_data_o,
	output reg irq_o
);
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam [TW-1:0] CYC_WORD = (`FPEC_T_WORD_NS + `FPEC_CLK_NS - 1) / `FPEC_CLK_NS;
	localparam [TW-1:0] CYC_ROW = (`FPEC_T_ROW_NS + `FPEC_CLK_NS - 1) / `FPEC_CLK_NS;
	localparam [TW-1:0] CYC_ERASE = (`FPEC_T_ERASE_NS + `FPEC_CLK_NS - 1) / `FPEC_CLK_NS;
	localparam [TW-1:0] CYC_CFG = (`FPEC_T_CFG_NS + `FPEC_CLK_NS - 1) / `FPEC_CLK_NS;
	localparam [TW-1:0] CYC_NOP = 1;

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_RUN = 2'b10;
	localparam [2:0] KEY_NONE = 3'b001;
	localparam [2:0] KEY_HALF = 3'b010;
	localparam [2:0] KEY_ARMED = 3'b100;

	// ----------------------------------------------------------------
	// reset synchroniser
	// ----------------------------------------------------------------
	reg rst_meta;
	reg rst_sync;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end
	wire rst_n = rst_sync;

	// ----------------------------------------------------------------
	// decode: {implemented, touches flash, command}
	// ----------------------------------------------------------------
	function [4:0] decode;
		input ers;
		input [3:0] code;
		begin
			decode = 5'h00;
			if (ers) begin
				case (code)
				4'hf: decode = {2'b11, `FPEC_CMD_BULK};
				4'hd: decode = {2'b11, `FPEC_CMD_GSEG};
				4'hc: decode = {2'b11, `FPEC_CMD_SSEG};
				4'h2: decode = {2'b11, `FPEC_CMD_PAGE};
				4'h0: decode = {2'b11, `FPEC_CMD_CFGE};
				4'h3, 4'h1, 4'he, 4'hb: decode = 5'h10;
				default: decode = 5'h00;
				endcase
			end else begin
				case (code)
				4'h3: decode = {2'b11, `FPEC_CMD_WORD};
				4'h1: decode = {2'b11, `FPEC_CMD_ROW};
				4'h0: decode = {2'b11, `FPEC_CMD_CFGP};
				4'hf, 4'hd, 4'hc, 4'h2, 4'he, 4'hb: decode = 5'h10;
				default: decode = 5'h00;
				endcase
			end
		end
	endfunction

	function [TW-1:0] duration;
		input [2:0] cmd;
		begin
			case (cmd)
			`FPEC_CMD_WORD: duration = CYC_WORD;
			`FPEC_CMD_ROW: duration = CYC_ROW;
			`FPEC_CMD_CFGE, `FPEC_CMD_CFGP: duration = CYC_CFG;
			default: duration = CYC_ERASE;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg start;
	reg program_erase_enable;
	reg err;
	reg erase;
	reg [3:0] op;
	reg [2:0] key_st;
	reg [1:0] st;
	reg [1:0] stat;
	reg [1:0] mask;
	reg [3:0] aw_addr;
	reg aw_hold;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg w_hold;

	wire do_wr = aw_hold && w_hold && !s_axi_bvalid;
	wire ctl_we = do_wr && aw_addr == `FPEC_OFS_CTRL;
	wire key_we = do_wr && aw_addr == `FPEC_OFS_KEY && w_strb[0];
	wire stat_we = do_wr && aw_addr == `FPEC_OFS_STAT && w_strb[0];
	wire mask_we = do_wr && aw_addr == `FPEC_OFS_MASK && w_strb[0];
	wire wr_hit = aw_addr == `FPEC_OFS_CTRL || aw_addr == `FPEC_OFS_KEY ||
		aw_addr == `FPEC_OFS_STAT || aw_addr == `FPEC_OFS_MASK;

	wire next_program_erase_enable = (ctl_we && w_strb[1]) ? w_data[`FPEC_BIT_PROGRAM_ERASE_ENABLE] : program_erase_enable;
	wire next_erase = (ctl_we && w_strb[0] && !start) ? w_data[`FPEC_BIT_ERASE] : erase;
	wire [3:0] next_op = (ctl_we && w_strb[0] && !start) ? w_data[3:0] : op;
	wire set_try = ctl_we && w_strb[1] && w_data[`FPEC_BIT_START];
	wire [4:0] dec = decode(next_erase, next_op);
	// key must be the write right before the start write
	wire unlocked = key_st == KEY_ARMED;
	wire launch = set_try && !start && unlocked && next_program_erase_enable && dec[4];
	wire bad_try = set_try && !launch;
	wire op_done;
	wire abort = st == ST_RUN && flash_fault_i;
	wire finish = op_done || abort;

	// ----------------------------------------------------------------
	// control register, power-on reset only
	// ----------------------------------------------------------------
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			start <= 1'b0;
			program_erase_enable <= 1'b0;
			err <= 1'b0;
			erase <= 1'b0;
			op <= 4'h0;
		end else if (ce_i) begin
			program_erase_enable <= next_program_erase_enable;
			erase <= next_erase;
			op <= next_op;
			if (launch) begin
				start <= 1'b1;
			end else if (finish) begin
				start <= 1'b0;
			end // a zero written to start is ignored
			// hardware set wins over a software write
			if (bad_try || abort) begin
				err <= 1'b1;
			end else if (launch) begin
				err <= 1'b0;
			end else if (ctl_we && w_strb[1]) begin
				err <= w_data[`FPEC_BIT_ERR];
			end
		end
	end

	// ----------------------------------------------------------------
	// unlock key sequence; other resets drop it
	// ----------------------------------------------------------------
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			key_st <= KEY_NONE;
		end else if (ce_i) begin
			if (sys_rst_i) begin
				key_st <= KEY_NONE;
			end else if (key_we) begin
				case (key_st)
				KEY_NONE: key_st <= (w_data[7:0] == `FPEC_KEY_FIRST) ? KEY_HALF : KEY_NONE;
				KEY_HALF: key_st <= (w_data[7:0] == `FPEC_KEY_SECOND) ? KEY_ARMED :
					(w_data[7:0] == `FPEC_KEY_FIRST) ? KEY_HALF : KEY_NONE;
				default: key_st <= (w_data[7:0] == `FPEC_KEY_FIRST) ? KEY_HALF : KEY_NONE;
				endcase
			end else if (do_wr) begin
				key_st <= KEY_NONE;
			end
		end
	end

	// ----------------------------------------------------------------
	// sequencer and flash command
	// ----------------------------------------------------------------
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st <= ST_IDLE;
			flash_start_o <= 1'b0;
			flash_cmd_o <= 3'h0;
			flash_busy_o <= 1'b0;
		end else if (ce_i) begin
			flash_start_o <= 1'b0;
			case (st)
			ST_IDLE: begin
				if (launch) begin
					st <= ST_RUN;
					flash_cmd_o <= dec[2:0];
					flash_start_o <= dec[3];
					flash_busy_o <= dec[3];
				end
			end
			ST_RUN: begin
				if (finish) begin
					st <= ST_IDLE;
					flash_busy_o <= 1'b0;
				end
			end
			default: st <= ST_IDLE;
			endcase
		end
	end

	fpec_op_timer #(
		.W(TW)
	) u_timer (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.ce_i(ce_i),
		.load_i(launch),
		.count_i(dec[3] ? duration(dec[2:0]) : CYC_NOP),
		.abort_i(abort),
		.done_o(op_done)
	);

	fpec_row_latch #(
		.AW(LAW)
	) u_latch (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.ce_i(ce_i),
		.clr_i(sys_rst_i),
		.low_we_i(table_write_low_i),
		.high_we_i(table_write_high_i),
		.addr_i(table_addr_i),
		.low_i(table_low_i),
		.high_i(table_high_i),
		.rd_addr_i(flash_latch_addr_i),
		.rd_data_o(flash_latch_data_o)
	);

	// ----------------------------------------------------------------
	// interrupt status, write one to clear, set wins
	// ----------------------------------------------------------------
	wire [1:0] ev = {bad_try || abort, op_done && !abort};
	wire [1:0] next_stat = (stat & ~(stat_we ? w_data[1:0] : 2'b00)) | ev;
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			stat <= 2'b00;
			mask <= 2'b00;
			irq_o <= 1'b0;
		end else if (ce_i) begin
			if (sys_rst_i) begin
				stat <= 2'b00;
				mask <= 2'b00;
				irq_o <= 1'b0;
			end else begin
				stat <= next_stat;
				if (mask_we) begin
					mask <= w_data[1:0];
				end
				irq_o <= |(next_stat & (mask_we ? w_data[1:0] : mask));
			end
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite write channels
	// ----------------------------------------------------------------
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			aw_hold <= 1'b0;
			aw_addr <= 4'h0;
			w_hold <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else if (ce_i) begin
			s_axi_awready <= !aw_hold && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_hold && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= {s_axi_awaddr[3:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read channels
	// ----------------------------------------------------------------
	wire [15:0] ctl_rd = {start, program_erase_enable, err, 6'h00, erase, 2'b00, op};
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else if (ce_i) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case ({s_axi_araddr[3:2], 2'b00})
				`FPEC_OFS_CTRL: s_axi_rdata <= {16'h0000, ctl_rd};
				`FPEC_OFS_KEY: s_axi_rdata <= 32'h00000000;
				`FPEC_OFS_STAT: s_axi_rdata <= {30'h00000000, stat};
				`FPEC_OFS_MASK: s_axi_rdata <= {30'h00000000, mask};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'b10;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// [hw/fpec_defs.vh]
/*
 constants of the flash program/erase control block: register offsets,
 field positions, key values, operation codes and operation times.
 assumes inclusion by bare name from the hw/ design files.
*/
`ifndef FPEC_DEFS_VH
`define FPEC_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FPEC_OFS_CTRL 4'h0
`define FPEC_OFS_KEY 4'h4
`define FPEC_OFS_STAT 4'h8
`define FPEC_OFS_MASK 4'hc

// ----------------------------------------------------------------
// control register fields and reset value, unlock key values
// ----------------------------------------------------------------
`define FPEC_BIT_START 15
`define FPEC_BIT_PROGRAM_ERASE_ENABLE 14
`define FPEC_BIT_ERR 13
`define FPEC_BIT_ERASE 6
`define FPEC_CTRL_RST 16'h0000
`define FPEC_KEY_FIRST 8'h55
`define FPEC_KEY_SECOND 8'haa

// ----------------------------------------------------------------
// status bits
// ----------------------------------------------------------------
`define FPEC_ST_DONE 0
`define FPEC_ST_ERR 1

// ----------------------------------------------------------------
// flash commands driven to the array
// ----------------------------------------------------------------
`define FPEC_CMD_BULK 3'h0
`define FPEC_CMD_GSEG 3'h1
`define FPEC_CMD_SSEG 3'h2
`define FPEC_CMD_PAGE 3'h3
`define FPEC_CMD_CFGE 3'h4
`define FPEC_CMD_WORD 3'h5
`define FPEC_CMD_ROW 3'h6
`define FPEC_CMD_CFGP 3'h7

// ----------------------------------------------------------------
// operation times in ns, clock period in ns
// ----------------------------------------------------------------
`define FPEC_CLK_NS 10
`define FPEC_T_WORD_NS 2000
`define FPEC_T_ROW_NS 16000
`define FPEC_T_ERASE_NS 20000
`define FPEC_T_CFG_NS 4000

`endif

// [hw/fpec_op_timer.v]
/*
 self-timing counter for one flash operation.
 assumes a load pulse only while idle; abort ends a count at once.
*/
`timescale 1ns/100ps
module fpec_op_timer #(
	parameter W = 16
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire ce_i,
	input wire load_i,
	input wire [W-1:0] count_i,
	input wire abort_i,
	output reg done_o
);
	reg [W-1:0] cnt;
	reg busy;

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= {W{1'b0}};
			busy <= 1'b0;
			done_o <= 1'b0;
		end else if (ce_i) begin
			done_o <= 1'b0;
			if (abort_i) begin
				busy <= 1'b0;
				cnt <= {W{1'b0}};
			end else if (load_i) begin
				busy <= 1'b1;
				cnt <= count_i;
			end else if (busy) begin
				if (cnt <= {{(W-1){1'b0}}, 1'b1}) begin
					busy <= 1'b0;
					done_o <= 1'b1;
				end else begin
					cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// [hw/fpec_row_latch.v]
/*
 row write latches: a low word then a high byte make one program word.
 assumes the flash array reads a latch by address, one cycle latency.
*/
`timescale 1ns/100ps
module fpec_row_latch #(
	parameter AW = 6
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire ce_i,
	input wire clr_i,
	input wire low_we_i,
	input wire high_we_i,
	input wire [AW-1:0] addr_i,
	input wire [15:0] low_i,
	input wire [7:0] high_i,
	input wire [AW-1:0] rd_addr_i,
	output reg [23:0] rd_data_o
);
	reg [23:0] mem [0:(1<<AW)-1];
	reg [15:0] low_hold;
	reg pend;

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_hold <= 16'h0000;
			pend <= 1'b0;
		end else if (ce_i) begin
			if (clr_i) begin
				pend <= 1'b0;
			end else if (low_we_i) begin
				low_hold <= low_i;
				pend <= 1'b1;
			end else if (high_we_i) begin
				pend <= 1'b0;
			end
		end
	end

	// a high byte with no low word before it is dropped
	always @(posedge clk_i) begin
		if (ce_i && high_we_i && pend && !clr_i) begin
			mem[addr_i] <= {high_i, low_hold};
		end
	end

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_o <= 24'h000000;
		end else if (ce_i) begin
			rd_data_o <= mem[rd_addr_i];
		end
	end
endmodule

// [bench/fpec_monitor.sv]
/*
 checker for the flash program/erase control top: unlock, decode, timing.
 assumes it is bound to fpec_top, ce_i high, full-word register writes.
*/
`timescale 1ns/100ps
module fpec_monitor (
	input wire clk_i,
	input wire rst_n_i,
	input wire sys_rst_i,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire flash_start_o,
	input wire [2:0] flash_cmd_o,
	input wire flash_busy_o,
	input wire flash_fault_i
);
// ----------------------------------------------------------------
// helper state
// ----------------------------------------------------------------
reg [3:0] wa;
reg [31:0] wd;
reg [3:0] ra;
reg bv_q;
reg [1:0] st;
reg [15:0] bcnt;
wire wdone = s_axi_bvalid && !bv_q;
wire [1:0] next_st = (wa != 4'h4) ? 2'd0 : (wd[7:0] == 8'h55) ? 2'd1 :
	(st == 2'd1 && wd[7:0] == 8'haa) ? 2'd2 : 2'd0;
function [3:0] dec(input [4:0] k);
	case (k)
	5'h1f: dec = 4'h8;
	5'h1d: dec = 4'h9;
	5'h1c: dec = 4'ha;
	5'h12: dec = 4'hb;
	5'h10: dec = 4'hc;
	5'h03: dec = 4'hd;
	5'h01: dec = 4'he;
	5'h00: dec = 4'hf;
	default: dec = 4'h0;
	endcase
endfunction
wire [3:0] exp_cmd = dec({wd[6], wd[3:0]});
// slack of two cycles for launch and clear edges
wire [15:0] dur = (flash_cmd_o == 3'h5) ? 16'd202 : (flash_cmd_o == 3'h6) ? 16'd1602 :
	(flash_cmd_o == 3'h4 || flash_cmd_o == 3'h7) ? 16'd402 : 16'd2002;
always @(posedge clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		wa <= 4'h0;
		wd <= 32'h0;
		ra <= 4'h0;
		bv_q <= 1'b0;
		st <= 2'd0;
		bcnt <= 16'h0;
	end else begin
		bv_q <= s_axi_bvalid;
		bcnt <= flash_busy_o ? bcnt + 16'h1 : 16'h0;
		if (s_axi_awvalid && s_axi_awready)
			wa <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready)
			wd <= s_axi_wdata;
		if (s_axi_arvalid && s_axi_arready)
			ra <= s_axi_araddr;
		if (sys_rst_i)
			st <= 2'd0;
		else if (wdone)
			st <= next_st;
	end
end
// ----------------------------------------------------------------
// assertions
// ----------------------------------------------------------------
default clocking cb @(posedge clk_i); endclocking
default disable iff (!rst_n_i);
AST_START_KEYED: assert property (flash_start_o |-> wdone && wa == 4'h0 && st == 2'd2
	&& wd[15] && wd[14]) else $error("start without key, enable or set write");
AST_CMD_DECODE: assert property (flash_start_o |-> exp_cmd[3] &&
	flash_cmd_o == exp_cmd[2:0]) else $error("flash command wrong for code");
AST_START_PULSE: assert property (flash_start_o |=> !flash_start_o)
	else $error("start pulse longer than one cycle");
AST_START_BUSY: assert property (flash_start_o |-> flash_busy_o)
	else $error("busy missing at start");
AST_NO_RESTART: assert property (flash_busy_o && $past(flash_busy_o) |-> !flash_start_o)
	else $error("start while running");
AST_CMD_HELD: assert property (flash_busy_o && !flash_start_o |-> $stable(flash_cmd_o))
	else $error("command changed while running");
AST_FAULT_STOP: assert property (flash_busy_o && flash_fault_i |=> !flash_busy_o)
	else $error("fault did not end operation");
AST_SELF_TIMED: assert property (flash_busy_o |-> bcnt <= dur)
	else $error("operation overran its time");
AST_UNUSED_ZERO: assert property (s_axi_rvalid && ra == 4'h0 |->
	(s_axi_rdata & 32'hffff1fb0) == 32'h0) else $error("unimplemented bits nonzero");
AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
	else $error("read answer late");
endmodule
bind fpec_top fpec_monitor u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i), .sys_rst_i(sys_rst_i),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.flash_start_o(flash_start_o), .flash_cmd_o(flash_cmd_o), .flash_busy_o(flash_busy_o),
	.flash_fault_i(flash_fault_i));

// [bench/fpec_flash_model.sv]
/*
 flash array model: counts launches, reads row latches while row programming.
 assumes latch data arrives one cycle after its address.
*/
`timescale 1ns/100ps
module fpec_flash_model #(
	parameter LAW = 6
) (
	input wire clk_i,
	input wire flash_start_i,
	input wire [2:0] flash_cmd_i,
	input wire flash_busy_i,
	input wire fault_req_i,
	output wire flash_fault_o,
	output reg [LAW-1:0] latch_addr_o,
	input wire [23:0] latch_data_i
);
reg [LAW-1:0] addr_q;
reg row_q;
reg [23:0] mem [0:(1<<LAW)-1];
integer n_start = 0;
reg [2:0] last_cmd = 3'h0;
initial latch_addr_o = {LAW{1'b0}};
// fault only when the bench orders one
assign flash_fault_o = fault_req_i;
always @(posedge clk_i) begin
	if (flash_start_i) begin
		n_start <= n_start + 1;
		last_cmd <= flash_cmd_i;
		latch_addr_o <= {LAW{1'b0}};
	end else if (flash_busy_i) begin
		latch_addr_o <= latch_addr_o + 1'b1;
	end
	addr_q <= latch_addr_o;
	row_q <= flash_busy_i && flash_cmd_i == 3'h6;
	if (row_q)
		mem[addr_q] <= latch_data_i;
end
endmodule

// [bench/tb.sv]
/*
 testbench of the flash program/erase control: register tasks and tests.
 assumes the top and the flash model files are compiled before it.
*/
`timescale 1ns/100ps
module tb;
// ----------------------------------------------------------------
// signals
// ----------------------------------------------------------------
logic clk_i = 1'b0;
logic rst_n_i = 1'b0;
logic ce_i = 1'b1;
logic sys_rst_i = 1'b0;
logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
logic [31:0] s_axi_wdata = 32'h0;
logic [3:0] s_axi_wstrb = 4'hf;
logic twl = 1'b0, twh = 1'b0, fault_req = 1'b0;
logic [5:0] taddr = 6'h0;
logic [15:0] tlow = 16'h0;
logic [7:0] thigh = 8'h0;
wire awready, wready, bvalid, arready, rvalid, fstart, fbusy, ffault, irq_o;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
wire [2:0] fcmd;
wire [5:0] laddr;
wire [23:0] ldata;
logic [31:0] d;
logic [1:0] r;
logic [4:0] e;
integer n_fail = 0, n_checks = 0, cyc = 0, i, n0;
fpec_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .sys_rst_i(sys_rst_i),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
	.s_axi_rready(s_axi_rready), .table_write_low_i(twl), .table_write_high_i(twh),
	.table_addr_i(taddr), .table_low_i(tlow), .table_high_i(thigh), .flash_start_o(fstart),
	.flash_cmd_o(fcmd), .flash_busy_o(fbusy), .flash_fault_i(ffault),
	.flash_latch_addr_i(laddr), .flash_latch_data_o(ldata), .irq_o(irq_o));
fpec_flash_model fm (.clk_i(clk_i), .flash_start_i(fstart), .flash_cmd_i(fcmd),
	.flash_busy_i(fbusy), .fault_req_i(fault_req), .flash_fault_o(ffault),
	.latch_addr_o(laddr), .latch_data_i(ldata));
initial forever #5 clk_i = ~clk_i;
// ----------------------------------------------------------------
// tasks
// ----------------------------------------------------------------
task give_verdict;
	if (n_fail == 0 && n_checks > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask
task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
	n_checks = n_checks + 1;
	if (got !== exp) begin
		n_fail = n_fail + 1;
		$display("[ERR] %s expected %h seen %h", nm, exp, got);
	end
endtask
task axw(input [3:0] a, input [31:0] v);
	@(posedge clk_i);
	s_axi_awaddr <= a;
	s_axi_wdata <= v;
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	s_axi_bready <= 1'b1;
	do begin
		@(posedge clk_i);
		if (awready)
			s_axi_awvalid <= 1'b0;
		if (wready)
			s_axi_wvalid <= 1'b0;
	end while (bvalid !== 1'b1);
	chk("bresp", {30'h0, bresp}, 32'h0);
	s_axi_bready <= 1'b0;
endtask
task axr(input [3:0] a);
	@(posedge clk_i);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'b1;
	s_axi_rready <= 1'b1;
	do begin
		@(posedge clk_i);
		if (arready)
			s_axi_arvalid <= 1'b0;
	end while (rvalid !== 1'b1);
	d = rdata;
	r = rresp;
	s_axi_rready <= 1'b0;
endtask
task unlock;
	axw(4'h4, 32'h55);
	axw(4'h4, 32'haa);
endtask
task idle2;
	repeat (2) @(posedge clk_i);
endtask
// class {0 run, 1 no-op, 2 unimplemented} and flash command
function [4:0] ecode(input [4:0] k);
	case (k)
	5'h1f: ecode = 5'h00;
	5'h1d: ecode = 5'h01;
	5'h1c: ecode = 5'h02;
	5'h12: ecode = 5'h03;
	5'h10: ecode = 5'h04;
	5'h03: ecode = 5'h05;
	5'h01: ecode = 5'h06;
	5'h00: ecode = 5'h07;
	5'h13, 5'h11, 5'h1e, 5'h1b, 5'h0f, 5'h0d, 5'h0c, 5'h02, 5'h0e, 5'h0b: ecode = 5'h08;
	default: ecode = 5'h10;
	endcase
endfunction
always @(posedge clk_i) begin
	cyc <= cyc + 1;
	if (cyc == 40000) begin
		n_fail = n_fail + 1;
		give_verdict;
	end
end
// ----------------------------------------------------------------
// tests
// ----------------------------------------------------------------
initial begin
	repeat (5) @(posedge clk_i);
	rst_n_i <= 1'b1;
	repeat (4) @(posedge clk_i);
	axr(4'h0);
	chk("ctrl_reset", d, 32'h0);
	// unaligned byte address falls on the control word
	axr(4'h2);
	chk("alias_resp", {30'h0, r}, 32'h0);
	axw(4'h0, 32'hc003);
	axr(4'h0);
	chk("nokey_ctrl", d & 32'hffffbfb0, 32'h2000);
	idle2;
	chk("irq_masked", {31'h0, irq_o}, 32'h0);
	axw(4'hc, 32'h3);
	idle2;
	chk("irq_on", {31'h0, irq_o}, 32'h1);
	axw(4'h8, 32'h3);
	idle2;
	chk("irq_clear", {31'h0, irq_o}, 32'h0);
	unlock;
	axw(4'h0, 32'h8003);
	axr(4'h0);
	chk("noen_ctrl", d & 32'ha000, 32'h2000);
	axr(4'h8);
	chk("noen_status", d, 32'h2);
	axw(4'h0, 32'h4001);
	@(posedge clk_i);
	taddr <= 6'h5;
	tlow <= 16'h1234;
	thigh <= 8'hab;
	twl <= 1'b1;
	@(posedge clk_i);
	twl <= 1'b0;
	twh <= 1'b1;
	@(posedge clk_i);
	twh <= 1'b0;
	for (i = 0; i < 32; i = i + 1) begin
		e = ecode(i[4:0]);
		n0 = fm.n_start;
		axw(4'h8, 32'h3);
		unlock;
		axw(4'h0, {16'h0, 8'hc0, 1'b0, i[4], 2'h0, i[3:0]});
		idle2;
		if (e[4:3] == 2'd0) begin
			axw(4'h0, {16'h0, 8'h40, 1'b0, i[4], 2'h0, i[3:0]});
			axr(4'h0);
			chk("start_held", {31'h0, d[15]}, 32'h1);
		end
		do axr(4'h0); while (d[15] === 1'b1);
		chk("ctrl_err", {31'h0, d[13]}, {31'h0, e[4]});
		chk("starts", fm.n_start - n0, {31'h0, e[4:3] == 2'd0});
		if (e[4:3] == 2'd0)
			chk("cmd", {29'h0, fm.last_cmd}, {29'h0, e[2:0]});
		axr(4'h8);
		chk("status", d, e[4] ? 32'h2 : 32'h1);
	end
	chk("latch_word", fm.mem[5], 32'hab1234);
	axw(4'h8, 32'h3);
	unlock;
	axw(4'h0, 32'hc001);
	idle2;
	fault_req <= 1'b1;
	repeat (3) @(posedge clk_i);
	fault_req <= 1'b0;
	axr(4'h0);
	chk("fault_ctrl", d, 32'h6001);
	unlock;
	@(posedge clk_i);
	sys_rst_i <= 1'b1;
	@(posedge clk_i);
	sys_rst_i <= 1'b0;
	axr(4'h0);
	chk("ctrl_sysrst", d, 32'h6001);
	axr(4'h8);
	chk("status_sysrst", d, 32'h0);
	// other reset must drop an armed key
	n0 = fm.n_start;
	axw(4'h0, 32'hc001);
	axr(4'h8);
	chk("sysrst_key", d, 32'h2);
	chk("sysrst_starts", fm.n_start - n0, 32'h0);
	@(posedge clk_i);
	rst_n_i <= 1'b0;
	idle2;
	rst_n_i <= 1'b1;
	repeat (4) @(posedge clk_i);
	axr(4'h0);
	chk("ctrl_por", d, 32'h0);
	give_verdict;
end
endmodule
